/* src/iom_pkg.sv */
// Notes on behaviour
// - opcode 00 1010 d ffff_fff increments the addressed register and sends the sum to the chosen target.
// - with target select 0 the result goes to the accumulator, with 1 it is written back to the register.
// - opcode 11 1000 kkkk_kkkk ORs the immediate byte into the accumulator and updates the zero flag.
// - opcode 00 0100 d ffff_fff ORs the accumulator with the register into the target and updates the zero flag.
// - opcode 00 1000 d ffff_fff copies the register value unchanged to the chosen target.
// - the copy updates the zero flag, so a copy back to the register tests it for zero.
package iom_pkg;
    localparam int          OPC_W         = 14;
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 7;
    localparam int          TSEL_BIT      = 7;
    localparam int          PRE_HI        = 13;
    localparam int          PRE_LO        = 8;
    localparam logic [5:0]  PRE_INC       = 6'h0A;
    localparam logic [5:0]  PRE_OR_IMM    = 6'h38;
    localparam logic [5:0]  PRE_OR_REG    = 6'h04;
    localparam logic [5:0]  PRE_COPY      = 6'h08;
    localparam logic [7:0]  ACC_RESET     = 8'h00;
    localparam logic        ZERO_RESET    = 1'b0;

    typedef enum logic [2:0] {
        IOM_OP_NONE   = 3'h0,
        IOM_OP_INC    = 3'h1,
        IOM_OP_OR_IMM = 3'h2,
        IOM_OP_OR_REG = 3'h3,
        IOM_OP_COPY   = 3'h4
    } iom_op_t;
endpackage

/* src/iom_decode.sv */
`timescale 1ns/1ns
module iom_decode
    import iom_pkg::*;
(
    input  wire logic [OPC_W-1:0]  opcode,
    output iom_op_t                op,
    output logic      [ADDR_W-1:0] reg_index,
    output logic                   target_select,
    output logic      [DATA_W-1:0] imm_byte
);
    // ----------------------------------------
    // opcode field split
    // ----------------------------------------
    always_comb begin
        reg_index     = opcode[ADDR_W-1:0];
        target_select = opcode[TSEL_BIT];
        imm_byte      = opcode[DATA_W-1:0];
        case (opcode[PRE_HI:PRE_LO])
            PRE_INC:    op = IOM_OP_INC;
            PRE_OR_IMM: op = IOM_OP_OR_IMM;
            PRE_OR_REG: op = IOM_OP_OR_REG;
            PRE_COPY:   op = IOM_OP_COPY;
            default:    op = IOM_OP_NONE;
        endcase
    end
endmodule

/* src/iom_exec.sv */
`timescale 1ns/1ns
module iom_exec
    import iom_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic              instr_valid,
    input  wire logic [OPC_W-1:0]  opcode,
    output logic      [ADDR_W-1:0] reg_rd_index,
    input  wire logic [DATA_W-1:0] reg_rd_data,
    output logic                   reg_wr_en,
    output logic      [ADDR_W-1:0] reg_wr_index,
    output logic      [DATA_W-1:0] reg_wr_data,
    output logic      [DATA_W-1:0] acc_value,
    output logic                   zero_flag,
    output logic                   instr_done
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        is_zero = (v == '0);
    endfunction

    function automatic logic [DATA_W-1:0] inc_wrap(input logic [DATA_W-1:0] v);
        logic [DATA_W:0] sum;
        sum      = {1'b0, v} + {{DATA_W{1'b0}}, 1'b1};
        inc_wrap = sum[DATA_W-1:0];
    endfunction

    function automatic logic [DATA_W-1:0] or_bytes(input logic [DATA_W-1:0] a,
                                                   input logic [DATA_W-1:0] b);
        or_bytes = a | b;
    endfunction

    function automatic logic to_accumulator(input iom_op_t o, input logic tsel);
        to_accumulator = (o == IOM_OP_OR_IMM) || !tsel;
    endfunction

    function automatic logic is_known(input iom_op_t o);
        is_known = (o != IOM_OP_NONE);
    endfunction

    // ----------------------------------------
    // decode
    // ----------------------------------------
    iom_op_t           op;
    logic [ADDR_W-1:0] reg_index;
    logic              target_select;
    logic [DATA_W-1:0] imm_byte;

    iom_decode u_decode (
        .opcode        (opcode),
        .op            (op),
        .reg_index     (reg_index),
        .target_select (target_select),
        .imm_byte      (imm_byte)
    );

    assign reg_rd_index = reg_index;

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [DATA_W-1:0] acc_reg;
    logic [DATA_W-1:0] acc_next;
    logic              zero_reg;
    logic              zero_next;
    logic              wr_reg;
    logic              wr_next;
    logic [ADDR_W-1:0] widx_reg;
    logic [ADDR_W-1:0] widx_next;
    logic [DATA_W-1:0] wdat_reg;
    logic [DATA_W-1:0] wdat_next;
    logic              done_reg;
    logic              done_next;

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    logic [DATA_W-1:0] inc_result;
    logic [DATA_W-1:0] or_imm_result;
    logic [DATA_W-1:0] or_reg_result;
    logic [DATA_W-1:0] copy_result;
    logic [DATA_W-1:0] result;
    logic              commit;
    logic              acc_dest;

    always_comb begin
        inc_result    = inc_wrap(reg_rd_data);
        or_imm_result = or_bytes(acc_reg, imm_byte);
        or_reg_result = or_bytes(acc_reg, reg_rd_data);
        copy_result   = reg_rd_data;
    end

    // ----------------------------------------
    // operation select
    // ----------------------------------------
    always_comb begin
        case (op)
            IOM_OP_INC: begin
                result = inc_result;
            end
            IOM_OP_OR_IMM: begin
                result = or_imm_result;
            end
            IOM_OP_OR_REG: begin
                result = or_reg_result;
            end
            IOM_OP_COPY: begin
                result = copy_result;
            end
            default: begin
                result = acc_reg;
            end
        endcase
    end

    // ----------------------------------------
    // execute strobe
    // ----------------------------------------
    always_comb begin
        commit   = instr_valid && is_known(op);
        acc_dest = to_accumulator(op, target_select);
    end

    // ----------------------------------------
    // accumulator
    // ----------------------------------------
    always_comb begin
        acc_next = acc_reg;
        if (commit && acc_dest) begin
            acc_next = result;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            acc_reg <= ACC_RESET;
        end else begin
            acc_reg <= acc_next;
        end
    end

    // ----------------------------------------
    // zero flag
    // ----------------------------------------
    always_comb begin
        zero_next = zero_reg;
        if (commit) begin
            zero_next = is_zero(result);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            zero_reg <= ZERO_RESET;
        end else begin
            zero_reg <= zero_next;
        end
    end

    // ----------------------------------------
    // write strobe
    // ----------------------------------------
    always_comb begin
        wr_next = 1'b0;
        if (commit && !acc_dest) begin
            wr_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wr_reg <= 1'b0;
        end else begin
            wr_reg <= wr_next;
        end
    end

    // ----------------------------------------
    // write index and data
    // ----------------------------------------
    always_comb begin
        widx_next = widx_reg;
        wdat_next = wdat_reg;
        if (commit && !acc_dest) begin
            widx_next = reg_index;
            wdat_next = result;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            widx_reg <= '0;
            wdat_reg <= '0;
        end else begin
            widx_reg <= widx_next;
            wdat_reg <= wdat_next;
        end
    end

    // ----------------------------------------
    // done pulse
    // ----------------------------------------
    always_comb begin
        done_next = commit;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= done_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_wr_en    = wr_reg;
    assign reg_wr_index = widx_reg;
    assign reg_wr_data  = wdat_reg;
    assign acc_value    = acc_reg;
    assign zero_flag    = zero_reg;
    assign instr_done   = done_reg;
endmodule

/* verif/iom_exec_sva.sv */
`timescale 1ns/1ns
module iom_exec_chk
    import iom_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rst_b,
    input wire logic              instr_valid,
    input wire logic [OPC_W-1:0]  opcode,
    input wire logic [ADDR_W-1:0] reg_rd_index,
    input wire logic [DATA_W-1:0] reg_rd_data,
    input wire logic              reg_wr_en,
    input wire logic [ADDR_W-1:0] reg_wr_index,
    input wire logic [DATA_W-1:0] reg_wr_data,
    input wire logic [DATA_W-1:0] acc_value,
    input wire logic              zero_flag,
    input wire logic              instr_done
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire logic [5:0] pre = opcode[13:8];
    wire logic       rop = instr_valid && pre inside {PRE_INC, PRE_OR_REG, PRE_COPY};
    a_inc_sum: assert property (instr_valid && pre == PRE_INC && !opcode[7] |=>
        acc_value == $past(reg_rd_data) + 8'h01) else $error("increment sum wrong");
    a_target_reg: assert property (rop && opcode[7] |=> reg_wr_en && $stable(acc_value)
        && reg_wr_index == $past(opcode[6:0])) else $error("register target wrong");
    a_or_imm: assert property (instr_valid && pre == PRE_OR_IMM |=> !reg_wr_en &&
        acc_value == ($past(acc_value) | $past(opcode[7:0]))) else $error("immediate or wrong");
    a_or_reg: assert property (instr_valid && pre == PRE_OR_REG && opcode[7] |=>
        reg_wr_data == ($past(acc_value) | $past(reg_rd_data))) else $error("register or wrong");
    a_copy_val: assert property (instr_valid && pre == PRE_COPY && opcode[7] |=>
        reg_wr_data == $past(reg_rd_data)) else $error("copy value wrong");
    a_copy_zero: assert property (instr_valid && pre == PRE_COPY |=>
        zero_flag == ($past(reg_rd_data) == 8'h00)) else $error("copy zero flag wrong");
    a_inc_wrap: assert property (instr_valid && pre == PRE_INC |=>
        zero_flag == ($past(reg_rd_data) == 8'hFF)) else $error("increment zero flag wrong");
    a_or_reg_acc: assert property (instr_valid && pre == PRE_OR_REG && !opcode[7] |=>
        acc_value == ($past(acc_value) | $past(reg_rd_data)) && !reg_wr_en)
        else $error("register or to accumulator wrong");
    a_copy_acc: assert property (instr_valid && pre == PRE_COPY && !opcode[7] |=>
        acc_value == $past(reg_rd_data) && !reg_wr_en) else $error("copy to accumulator wrong");
    a_done_pulse: assert property (rop || (instr_valid && pre == PRE_OR_IMM) |=>
        instr_done) else $error("done pulse missing");
    a_refused_quiet: assert property (rst_b && !rop && !(instr_valid && pre == PRE_OR_IMM) |=>
        !instr_done && !reg_wr_en && $stable(acc_value) && $stable(zero_flag))
        else $error("refused instruction changed state");
endmodule
bind iom_exec iom_exec_chk iom_exec_chk_inst (.sys_clk, .rst_b, .instr_valid, .opcode,
    .reg_rd_index, .reg_rd_data, .reg_wr_en, .reg_wr_index, .reg_wr_data, .acc_value,
    .zero_flag, .instr_done);

/* verif/iom_regfile.sv */
`timescale 1ns/1ns
module iom_regfile
    import iom_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic [ADDR_W-1:0] rd_index,
    output logic     [DATA_W-1:0] rd_data,
    input wire logic              wr_en,
    input wire logic [ADDR_W-1:0] wr_index,
    input wire logic [DATA_W-1:0] wr_data
);
    logic [DATA_W-1:0] mem [128];
    // forward a write still in flight
    assign rd_data = (wr_en && wr_index == rd_index) ? wr_data : mem[rd_index];
    always @(posedge sys_clk) if (wr_en) mem[wr_index] <= wr_data;
endmodule

/* verif/iom_exec_tb.sv */
`timescale 1ns/1ns
module iom_exec_tb;
    import iom_pkg::*;
    logic sys_clk = 0, rst_b = 0, instr_valid = 0, reg_wr_en, zero_flag, instr_done;
    logic [OPC_W-1:0]  opcode = '0;
    logic [ADDR_W-1:0] reg_rd_index, reg_wr_index;
    logic [DATA_W-1:0] reg_rd_data, reg_wr_data, acc_value;
    int fail_count = 0, comparisons = 0, cyc = 0;
    iom_exec iom_exec_inst (.sys_clk, .rst_b, .instr_valid, .opcode, .reg_rd_index,
        .reg_rd_data, .reg_wr_en, .reg_wr_index, .reg_wr_data, .acc_value, .zero_flag,
        .instr_done);
    iom_regfile iom_regfile_inst (.sys_clk, .rd_index(reg_rd_index), .rd_data(reg_rd_data),
        .wr_en(reg_wr_en), .wr_index(reg_wr_index), .wr_data(reg_wr_data));
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 300) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic run(input logic [13:0] op);
        @(posedge sys_clk);
        opcode <= op;
        instr_valid <= 1'b1;
        @(posedge sys_clk);
        instr_valid <= 1'b0;
        #1;
    endtask
    task automatic t_inc();
        iom_regfile_inst.mem[5] = 8'hFF;
        run(14'h0A85);
        chk(reg_wr_en, 1);
        chk(reg_wr_data, 8'h00);
        chk(zero_flag, 1);
        chk(instr_done, 1);
        chk(reg_rd_index, 8'h05);
        run(14'h0A05);
        chk(acc_value, 8'h01);
        chk(zero_flag, 0);
        $display("inc test done");
    endtask
    task automatic t_or();
        iom_regfile_inst.mem[3] = 8'h9A;
        iom_regfile_inst.mem[2] = 8'h40;
        run(14'h0803);
        chk(acc_value, 8'h9A);
        run(14'h3835);
        chk(acc_value, 8'hBF);
        chk({reg_wr_en, zero_flag}, 0);
        run(14'h0482);
        chk(reg_wr_en, 1);
        chk(reg_wr_data, 8'hFF);
        chk(reg_wr_index, 2);
        chk(acc_value, 8'hBF);
        run(14'h0402);
        chk(acc_value, 8'hFF);
        $display("or test done");
    endtask
    task automatic t_copy();
        iom_regfile_inst.mem[6] = 8'h00;
        run(14'h0886);
        chk(reg_wr_en, 1);
        chk(zero_flag, 1);
        chk(reg_wr_data, 8'h00);
        chk(acc_value, 8'hFF);
        run(14'h3F00);
        chk(instr_done, 0);
        chk(zero_flag, 1);
        $display("copy test done");
    endtask
    task automatic t_reset();
        @(posedge sys_clk);
        rst_b <= 1'b0;
        @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        chk(acc_value, ACC_RESET);
        chk(zero_flag, ZERO_RESET);
        run(14'h3800);
        chk(acc_value, 8'h00);
        chk(zero_flag, 1);
        $display("reset test done");
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_inc();
        t_or();
        t_copy();
        t_reset();
        finish_test();
    end
endmodule
